// ===== hdl/tfac_ctrl.sv
// Table access and nonvolatile memory control unit
`timescale 1ns/1ps
module tfac_ctrl
	import tfac_pkg::*;
#(
	parameter int HOLD_BYTES = 32                       // 8, 16 or 32
) (
	input  wire logic               sys_clk_in,         // System clock
	input  wire logic               rst_in,             // Synchronous reset
	input  wire logic [REG_AW-1:0]  reg_addr_in,        // Register address
	input  wire logic [DW-1:0]      reg_wdata_in,       // Register write data
	input  wire logic               reg_wr_in,          // Register write strobe
	input  wire logic               reg_rd_in,          // Register read strobe
	output logic      [DW-1:0]      reg_rdata_out,      // Read data, next cycle
	input  wire logic               op_valid_in,        // Table op request
	input  wire logic               op_store_in,        // 1 store, 0 read
	input  wire logic [1:0]         op_mode_in,         // Pointer update mode
	output logic                    op_busy_out,        // Table ops ignored
	output logic                    mem_rd_out,         // Array read pulse
	output logic                    mem_wr_out,         // Array byte load pulse
	output logic                    mem_erase_out,      // Array erase pulse
	output logic                    mem_prog_out,       // Array program pulse
	output logic      [1:0]         mem_space_out,      // Array space
	output logic      [PTR_W-1:0]   mem_addr_out,       // Array byte address
	output logic      [DW-1:0]      mem_wdata_out,      // Array write byte
	input  wire logic [DW-1:0]      mem_rdata_in,       // Array read byte
	input  wire logic               mem_fault_in,       // Array reports failure
	output logic                    done_flag_out,      // Memory done flag
	output logic                    write_active_out    // Write start bit
);
	localparam int IDX_W = $clog2(HOLD_BYTES);

	// ==========================================================
	// Pointer arithmetic on the low 21 bits only
	function automatic logic [PTR_W-1:0] ptr_add(input logic [PTR_W-1:0] p,
		input logic dec);
		logic [PTR_LOW_W-1:0] lo;
		lo = dec ? (p[PTR_LOW_W-1:0] - PTR_LOW_W'(1)) : (p[PTR_LOW_W-1:0] + PTR_LOW_W'(1));
		return {p[PTR_CFG_BIT], lo};
	endfunction

	function automatic tfac_space_e region_space(input logic [1:0] r);
		if (r[0]) begin
			return SP_CFG;
		end else if (r[1]) begin
			return SP_FLASH;
		end else begin
			return SP_EEPROM;
		end
	endfunction

	// ==========================================================
	// State
	tfac_state_e        state_r, state_nxt;
	logic [1:0]         region_r, region_nxt;
	logic               erase_sel_r, erase_sel_nxt;
	logic               permit_r, permit_nxt;
	logic               start_r, start_nxt;
	logic               fault_r, fault_nxt;
	logic               done_r, done_nxt;
	logic [1:0]         unlock_r, unlock_nxt;
	logic [DW-1:0]      latch_r, latch_nxt;
	logic [PTR_W-1:0]   ptr_r, ptr_nxt;
	logic               rd_pend_r, rd_pend_nxt;
	logic               do_erase_r, do_erase_nxt;
	logic               is_ee_r, is_ee_nxt;
	logic [IDX_W-1:0]   idx_r, idx_nxt;
	logic               tmr_start_r, tmr_start_nxt;
	logic [DW-1:0]      rdata_nxt;
	logic               busy_nxt;
	logic               mrd_nxt, mwr_nxt, mer_nxt, mpg_nxt;
	logic [1:0]         msp_nxt;
	logic [PTR_W-1:0]   maddr_nxt;
	logic [DW-1:0]      mwd_nxt;
	logic               tmr_expired;
	logic [PTR_W-1:0]   op_addr;
	logic               ctl_wr, launch;

	tfac_hold_if #(.IDX_W(IDX_W)) hif ();

	// ==========================================================
	// Holding register block and programming timer
	tfac_hold_buf #(
		.DEPTH (HOLD_BYTES),
		.IDX_W (IDX_W)
	) u_hold (
		.clk_in (sys_clk_in),
		.rst_in (rst_in),
		.hif    (hif.store)
	);

	tfac_prog_timer #(
		.CYCLES (PROG_CYCLES)
	) u_timer (
		.clk_in      (sys_clk_in),
		.rst_in      (rst_in),
		.start_in    (tmr_start_r),
		.expired_out (tmr_expired)
	);

	// Pre-increment addresses the next byte before the access
	assign op_addr = (op_mode_in == PM_PRE_INC) ? ptr_add(ptr_r, 1'b0) : ptr_r;
	assign ctl_wr  = reg_wr_in && (reg_addr_in == OFS_CONTROL);
	// A start is honoured only after both keys and with permit granted
	assign launch  = ctl_wr && reg_wdata_in[CB_START] && !start_r
		&& (unlock_r == 2'd2) && reg_wdata_in[CB_PERMIT];

	// ==========================================================
	// Next-state logic of the whole controller
	always_comb begin
		state_nxt     = state_r;
		region_nxt    = region_r;
		erase_sel_nxt = erase_sel_r;
		permit_nxt    = permit_r;
		start_nxt     = start_r;
		fault_nxt     = fault_r;
		done_nxt      = done_r;
		unlock_nxt    = unlock_r;
		latch_nxt     = latch_r;
		ptr_nxt       = ptr_r;
		rd_pend_nxt   = 1'b0;
		do_erase_nxt  = do_erase_r;
		is_ee_nxt     = is_ee_r;
		idx_nxt       = idx_r;
		tmr_start_nxt = 1'b0;
		rdata_nxt     = RST_BYTE;
		mrd_nxt       = 1'b0;
		mwr_nxt       = 1'b0;
		mer_nxt       = 1'b0;
		mpg_nxt       = 1'b0;
		msp_nxt       = mem_space_out;
		maddr_nxt     = mem_addr_out;
		mwd_nxt       = mem_wdata_out;
		hif.wr        = 1'b0;
		hif.widx      = op_addr[IDX_W-1:0];
		hif.wdata     = latch_r;
		hif.ridx      = idx_r;

		// Register reads answer one cycle later; unmapped reads give zero
		if (reg_rd_in) begin
			unique case (reg_addr_in)
				OFS_CONTROL: begin
					rdata_nxt[CB_REGION_HI:CB_REGION_LO] = region_r;
					rdata_nxt[CB_ERASE_SEL] = erase_sel_r;
					rdata_nxt[CB_FAULT]     = fault_r;
					rdata_nxt[CB_PERMIT]    = permit_r;
					rdata_nxt[CB_START]     = start_r;
				end
				OFS_UNLOCK:    rdata_nxt = RST_BYTE;
				OFS_LATCH:     rdata_nxt = latch_r;
				OFS_PTR_LOW:   rdata_nxt = ptr_r[7:0];
				OFS_PTR_HIGH:  rdata_nxt = ptr_r[15:8];
				OFS_PTR_UPPER: rdata_nxt = DW'(ptr_r[PTR_W-1:16]);
				OFS_FLAG7:     rdata_nxt[FB_DONE] = done_r;
				default:       rdata_nxt = RST_BYTE;
			endcase
		end

		// Register writes; any write other than a key breaks the sequence
		if (reg_wr_in) begin
			unlock_nxt = 2'd0;
			unique case (reg_addr_in)
				OFS_CONTROL: begin
					permit_nxt = reg_wdata_in[CB_PERMIT];
					// Target and mode stay frozen while a write runs
					if (!start_r) begin
						region_nxt    = reg_wdata_in[CB_REGION_HI:CB_REGION_LO];
						erase_sel_nxt = reg_wdata_in[CB_ERASE_SEL];
					end
				end
				OFS_UNLOCK: begin
					// Keys land in the sequencer only, nothing is stored
					if (reg_wdata_in == UNLOCK_KEY_A) begin
						unlock_nxt = 2'd1;
					end else if (reg_wdata_in == UNLOCK_KEY_B && unlock_r == 2'd1) begin
						unlock_nxt = 2'd2;
					end
				end
				OFS_LATCH:     latch_nxt = reg_wdata_in;
				OFS_PTR_LOW:   ptr_nxt[7:0] = reg_wdata_in;
				OFS_PTR_HIGH:  ptr_nxt[15:8] = reg_wdata_in;
				OFS_PTR_UPPER: ptr_nxt[PTR_W-1:16] = reg_wdata_in[UPPER_W-1:0];
				OFS_FLAG7: begin
					if (!reg_wdata_in[FB_DONE]) begin
						done_nxt = 1'b0;
					end
				end
				default: ;
			endcase
		end

		// Launch a write; writing zero to start does nothing
		if (launch) begin
			start_nxt    = 1'b1;
			fault_nxt    = 1'b1;
			// The control write that sets start also picks target and mode
			is_ee_nxt    = (region_space(region_nxt) == SP_EEPROM);
			do_erase_nxt = erase_sel_nxt && !is_ee_nxt;
			msp_nxt      = region_space(region_nxt);
			idx_nxt      = '0;
			if (is_ee_nxt) begin
				// EEPROM: one byte, then a combined erase and write
				mwr_nxt   = 1'b1;
				maddr_nxt = ptr_r;
				mwd_nxt   = latch_r;
				state_nxt = ST_FIRE;
			end else if (do_erase_nxt) begin
				state_nxt = ST_FIRE;
			end else begin
				state_nxt = ST_COPY;
			end
		end

		// Table ops are ignored while a write runs or a read is in flight
		if (op_valid_in && !start_r && !rd_pend_r) begin
			if (op_store_in) begin
				hif.wr = 1'b1;
			end else begin
				mrd_nxt     = 1'b1;
				maddr_nxt   = op_addr;
				msp_nxt     = op_addr[PTR_CFG_BIT] ? SP_CFG : SP_FLASH;
				rd_pend_nxt = 1'b1;
			end
			unique case (tfac_ptr_mode_e'(op_mode_in))
				PM_NONE:     ptr_nxt = ptr_r;
				PM_POST_INC: ptr_nxt = ptr_add(ptr_r, 1'b0);
				PM_POST_DEC: ptr_nxt = ptr_add(ptr_r, 1'b1);
				PM_PRE_INC:  ptr_nxt = op_addr;
			endcase
		end

		// Read byte is taken in the same cycle as the array read pulse
		if (rd_pend_r) begin
			latch_nxt = mem_rdata_in;
		end

		// Write sequencer
		unique case (state_r)
			ST_IDLE: ;
			ST_COPY: begin
				// Stream the whole block to the aligned block address
				mwr_nxt   = 1'b1;
				mwd_nxt   = hif.rdata;
				maddr_nxt = {ptr_r[PTR_W-1:IDX_W], idx_r};
				idx_nxt   = idx_r + IDX_W'(1);
				if (idx_r == IDX_W'(HOLD_BYTES - 1)) begin
					state_nxt = ST_FIRE;
				end
			end
			ST_FIRE: begin
				if (do_erase_r && !is_ee_r) begin
					mer_nxt   = 1'b1;
					maddr_nxt = {ptr_r[PTR_W-1:IDX_W], IDX_W'(0)};
				end else begin
					mpg_nxt = 1'b1;
				end
				tmr_start_nxt = 1'b1;
				state_nxt     = ST_WAIT;
			end
			ST_WAIT: begin
				if (tmr_expired) begin
					start_nxt = 1'b0;
					done_nxt  = 1'b1;
					// Fault stays set when the array reports a failure
					if (!mem_fault_in) begin
						fault_nxt = 1'b0;
					end
					state_nxt = ST_IDLE;
				end
			end
		endcase

		busy_nxt = start_nxt || rd_pend_nxt;
	end

	// ==========================================================
	// Registers of the controller; permit and all flags clear at reset
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			state_r          <= ST_IDLE;
			region_r         <= RGN_EEPROM;
			erase_sel_r      <= 1'b0;
			permit_r         <= 1'b0;
			start_r          <= 1'b0;
			fault_r          <= 1'b0;
			done_r           <= 1'b0;
			unlock_r         <= 2'd0;
			latch_r          <= RST_BYTE;
			ptr_r            <= '0;
			rd_pend_r        <= 1'b0;
			do_erase_r       <= 1'b0;
			is_ee_r          <= 1'b0;
			idx_r            <= '0;
			tmr_start_r      <= 1'b0;
			reg_rdata_out    <= RST_BYTE;
			op_busy_out      <= 1'b0;
			mem_rd_out       <= 1'b0;
			mem_wr_out       <= 1'b0;
			mem_erase_out    <= 1'b0;
			mem_prog_out     <= 1'b0;
			mem_space_out    <= SP_NONE;
			mem_addr_out     <= '0;
			mem_wdata_out    <= RST_BYTE;
			done_flag_out    <= 1'b0;
			write_active_out <= 1'b0;
		end else begin
			state_r          <= state_nxt;
			region_r         <= region_nxt;
			erase_sel_r      <= erase_sel_nxt;
			permit_r         <= permit_nxt;
			start_r          <= start_nxt;
			fault_r          <= fault_nxt;
			done_r           <= done_nxt;
			unlock_r         <= unlock_nxt;
			latch_r          <= latch_nxt;
			ptr_r            <= ptr_nxt;
			rd_pend_r        <= rd_pend_nxt;
			do_erase_r       <= do_erase_nxt;
			is_ee_r          <= is_ee_nxt;
			idx_r            <= idx_nxt;
			tmr_start_r      <= tmr_start_nxt;
			reg_rdata_out    <= rdata_nxt;
			op_busy_out      <= busy_nxt;
			mem_rd_out       <= mrd_nxt;
			mem_wr_out       <= mwr_nxt;
			mem_erase_out    <= mer_nxt;
			mem_prog_out     <= mpg_nxt;
			mem_space_out    <= msp_nxt;
			mem_addr_out     <= maddr_nxt;
			mem_wdata_out    <= mwd_nxt;
			done_flag_out    <= done_nxt;
			write_active_out <= start_nxt;
		end
	end
endmodule

// ===== hdl/tfac_hold_buf.sv
// Flash holding register block, one flop byte per write block position
`timescale 1ns/1ps
module tfac_hold_buf
	import tfac_pkg::*;
#(
	parameter int DEPTH = 32,
	parameter int IDX_W = 5
) (
	input  wire logic   clk_in,  // System clock
	input  wire logic   rst_in,  // Synchronous reset
	tfac_hold_if.store  hif      // Controller side
);
	logic [7:0] mem_r   [DEPTH];
	logic [7:0] mem_nxt [DEPTH];

	// ==========================================================
	// Next contents: one byte may change per cycle
	always_comb begin
		mem_nxt = mem_r;
		if (hif.wr) begin
			mem_nxt[hif.widx] = hif.wdata;
		end
	end

	// Reset to the erased pattern so an unwritten slot programs nothing
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= ERASED_BYTE;
			end
		end else begin
			mem_r <= mem_nxt;
		end
	end

	assign hif.rdata = mem_r[hif.ridx];
endmodule

// ===== hdl/tfac_hold_if.sv
// Interface between the controller and the flash holding register block
`timescale 1ns/1ps
interface tfac_hold_if #(parameter int IDX_W = 5);
	logic             wr;     // Store one byte
	logic [IDX_W-1:0] widx;   // Store index
	logic [7:0]       wdata;  // Store byte
	logic [IDX_W-1:0] ridx;   // Read index
	logic [7:0]       rdata;  // Read byte
	modport ctrl  (output wr, widx, wdata, ridx, input rdata);
	modport store (input wr, widx, wdata, ridx, output rdata);
endinterface

// ===== hdl/tfac_pkg.sv
// Shared constants and types of the table access and nonvolatile control block
package tfac_pkg;

	// ==========================================================
	// Register port and map
	localparam int        REG_AW          = 3;
	localparam int        DW              = 8;
	localparam logic [2:0] OFS_CONTROL    = 3'h0;
	localparam logic [2:0] OFS_UNLOCK     = 3'h1;
	localparam logic [2:0] OFS_LATCH      = 3'h2;
	localparam logic [2:0] OFS_PTR_LOW    = 3'h3;
	localparam logic [2:0] OFS_PTR_HIGH   = 3'h4;
	localparam logic [2:0] OFS_PTR_UPPER  = 3'h5;
	localparam logic [2:0] OFS_FLAG7      = 3'h6;

	// ==========================================================
	// Field positions of the nonvolatile control register and of the done flag register
	localparam int        CB_REGION_HI    = 7;
	localparam int        CB_REGION_LO    = 6;
	localparam int        CB_ERASE_SEL    = 4;
	localparam int        CB_FAULT        = 3;
	localparam int        CB_PERMIT       = 2;
	localparam int        CB_START        = 1;
	localparam int        FB_DONE         = 0;

	// ==========================================================
	// Reset values and unlock keys
	localparam logic [7:0] RST_BYTE       = 8'h00;
	localparam logic [7:0] ERASED_BYTE    = 8'hFF;
	localparam logic [7:0] UNLOCK_KEY_A   = 8'h55;
	localparam logic [7:0] UNLOCK_KEY_B   = 8'hAA;

	// ==========================================================
	// Table pointer
	localparam int        PTR_W           = 22;
	localparam int        PTR_LOW_W       = 21;
	localparam int        PTR_CFG_BIT     = 21;
	localparam int        UPPER_W         = PTR_W - 16;

	// ==========================================================
	// Timing of the internal programming timer
	localparam int        CLK_PERIOD_NS   = 10;
	localparam int        PROG_TIME_NS    = 2000;
	localparam int        PROG_CYCLES     = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================
	// Enumerations
	typedef enum logic [1:0] {
		RGN_EEPROM = 2'b00,
		RGN_CFG    = 2'b01,
		RGN_FLASH  = 2'b10,
		RGN_CFG_B  = 2'b11
	} tfac_region_e;

	typedef enum logic [1:0] {
		SP_EEPROM = 2'b00,
		SP_FLASH  = 2'b01,
		SP_CFG    = 2'b10,
		SP_NONE   = 2'b11
	} tfac_space_e;

	typedef enum logic [1:0] {
		PM_NONE     = 2'b00,
		PM_POST_INC = 2'b01,
		PM_POST_DEC = 2'b10,
		PM_PRE_INC  = 2'b11
	} tfac_ptr_mode_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_COPY = 2'b01,
		ST_FIRE = 2'b10,
		ST_WAIT = 2'b11
	} tfac_state_e;

endpackage

// ===== hdl/tfac_prog_timer.sv
// Internal programming timer: one pulse a fixed count after a start pulse
`timescale 1ns/1ps
module tfac_prog_timer
	import tfac_pkg::*;
#(
	parameter int CYCLES = PROG_CYCLES
) (
	input  wire logic clk_in,      // System clock
	input  wire logic rst_in,      // Synchronous reset
	input  wire logic start_in,    // Start pulse
	output logic      expired_out  // One-cycle expiry pulse
);
	localparam int CW = $clog2(CYCLES + 1);
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic          exp_nxt;

	// ==========================================================
	// Count down; a restart while running reloads the full time
	always_comb begin
		cnt_nxt = cnt_r;
		exp_nxt = 1'b0;
		if (start_in) begin
			cnt_nxt = CW'(CYCLES);
		end else if (cnt_r != '0) begin
			cnt_nxt = cnt_r - CW'(1);
			exp_nxt = (cnt_r == CW'(1));
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cnt_r       <= '0;
			expired_out <= 1'b0;
		end else begin
			cnt_r       <= cnt_nxt;
			expired_out <= exp_nxt;
		end
	end
endmodule

// ===== tb/testbench.sv
// Self-checking testbench of the table access control block
`timescale 1ns/1ps
module testbench;
	import tfac_pkg::*;
	localparam int HB = 8;
	logic sys_clk_in = 1'b0, rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
	logic op_valid_in = 1'b0, op_store_in = 1'b0, fault_cmd = 1'b0;
	logic [REG_AW-1:0] reg_addr_in = '0;
	logic [DW-1:0] reg_wdata_in = '0, reg_rdata_out, mem_wdata_out, mem_rdata_in, lat;
	logic [1:0] op_mode_in = '0, mem_space_out;
	logic [PTR_W-1:0] mem_addr_out;
	logic op_busy_out, mem_rd_out, mem_wr_out, mem_erase_out, mem_prog_out, mem_fault_in;
	logic done_flag_out, write_active_out;
	logic [7:0] hold [HB];
	int num_errors = 0, samples_checked = 0, seed = 84737, n_erase = 0, ptr, p, m, ea, nq;
	int wq[$];

	tfac_ctrl #(.HOLD_BYTES(HB)) i_tfac_ctrl (.*);
	tfac_mem_model i_tfac_mem_model (.clk_in(sys_clk_in), .rd_in(mem_rd_out),
		.addr_in(mem_addr_out), .fail_in(fault_cmd), .rdata_out(mem_rdata_in),
		.fault_out(mem_fault_in));

	always #5 sys_clk_in = ~sys_clk_in;
	// Log every byte load and erase seen on the array side
	always @(posedge sys_clk_in) begin
		if (mem_erase_out)
			n_erase++;
		if (mem_wr_out)
			wq.push_back({mem_space_out, mem_addr_out, mem_wdata_out});
	end

	// ==========================================================
	// Tasks
	task automatic report_and_stop();
		$display("Checks %0d, errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(logic [2:0] a, logic [7:0] v);
		@(posedge sys_clk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= v;
		@(posedge sys_clk_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rchk(string n, logic [2:0] a, logic [7:0] e);
		@(posedge sys_clk_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge sys_clk_in);
		reg_rd_in <= 1'b0;
		#1 chk(n, reg_rdata_out, e);
	endtask
	task automatic op(logic s, logic [1:0] md);
		@(posedge sys_clk_in);
		op_valid_in <= 1'b1;
		op_store_in <= s;
		op_mode_in <= md;
		@(posedge sys_clk_in);
		op_valid_in <= 1'b0;
	endtask
	function automatic int step(int v, int k);
		return (v & 32'h200000) | ((v + k) & 32'h1FFFFF);
	endfunction
	// Upper bits 7:6 are written as ones and must read back as zero
	task automatic setp(int v);
		wr(OFS_PTR_LOW, v[7:0]);
		wr(OFS_PTR_HIGH, v[15:8]);
		wr(OFS_PTR_UPPER, {2'h3, v[21:16]});
	endtask
	task automatic chkp();
		rchk("ptr_lo", OFS_PTR_LOW, ptr[7:0]);
		rchk("ptr_hi", OFS_PTR_HIGH, ptr[15:8]);
		rchk("ptr_up", OFS_PTR_UPPER, {2'h0, ptr[21:16]});
	endtask
	task automatic unl(logic [7:0] ctl);
		wr(OFS_UNLOCK, UNLOCK_KEY_A);
		wr(OFS_UNLOCK, UNLOCK_KEY_B);
		wr(OFS_CONTROL, ctl);
	endtask
	// Full write: start, try to clear start, wait bounded, then check flags
	task automatic nvw(logic [7:0] ctl, logic f);
		fault_cmd <= f;
		unl(ctl);
		rchk("start_fault", OFS_CONTROL, ctl | 8'h0A);
		wr(OFS_CONTROL, ctl & 8'hFD);
		#1 chk("start_held", write_active_out, 1'b1);
		for (int i = 0; i < 1000; i++) begin
			@(posedge sys_clk_in);
			#1;
			if (!write_active_out)
				break;
		end
		chk("start_clear", write_active_out, 1'b0);
		rchk("ctl_after", OFS_CONTROL, (ctl & 8'hD4) | {4'h0, f, 3'h0});
		wr(OFS_FLAG7, 8'h01);
		rchk("done_kept", OFS_FLAG7, 8'h01);
		wr(OFS_FLAG7, 8'h00);
		rchk("done_clr", OFS_FLAG7, 8'h00);
		fault_cmd <= 1'b0;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		repeat (6) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		for (int a = 0; a < 8; a++)
			rchk("reset", a[2:0], RST_BYTE);
		wr(3'h7, 8'hFF);
		wr(OFS_UNLOCK, 8'hC3);
		rchk("unmapped", 3'h7, 8'h00);
		rchk("unlock_rd", OFS_UNLOCK, 8'h00);
		// Reads in all four pointer modes, both wrap points first
		for (int i = 0; i < 6; i++) begin
			p = (i == 0) ? 32'h3FFFFF : (i == 1) ? 32'h200000 : $random(seed) & 32'h3FFFFF;
			m = (i + 1) % 4;
			setp(p);
			op(1'b0, m[1:0]);
			ea = (m == 3) ? step(p, 1) : p;
			#1 chk("rd_strobe", mem_rd_out, 1'b1);
			chk("rd_addr", mem_addr_out, ea);
			chk("rd_space", mem_space_out, ea[21] ? SP_CFG : SP_FLASH);
			ptr = (m == 2) ? step(p, -1) : (m == 0) ? p : step(p, 1);
			rchk("latch", OFS_LATCH, ea[7:0] ^ ea[15:8] ^ 8'h5A);
			chkp();
		end
		// Start refused without permit, and without the unlock keys
		unl(8'h82);
		repeat (2) @(posedge sys_clk_in);
		chk("no_permit", write_active_out, 1'b0);
		// Stores from an unaligned start cross a block boundary
		ptr = $random(seed) & 32'h1FFFFF;
		setp(ptr);
		for (int j = 0; j < HB; j++) begin
			lat = $random(seed);
			wr(OFS_LATCH, lat);
			op(1'b1, 2'h1);
			hold[ptr % HB] = lat;
			ptr = step(ptr, 1);
		end
		chkp();
		wr(OFS_CONTROL, 8'h86);
		repeat (2) @(posedge sys_clk_in);
		chk("no_unlock", write_active_out, 1'b0);
		nq = wq.size();
		nvw(8'h86, 1'b0);
		chk("blk_n", wq.size(), nq + HB);
		for (int k = 0; k < HB; k++)
			chk("blk", wq[nq + k], {2'h1, 22'((ptr & ~(HB - 1)) | k), hold[k]});
		// EEPROM write with erase select set: load plus commit, no erase
		ptr = $random(seed) & 32'h1FFFFF;
		setp(ptr);
		lat = $random(seed);
		wr(OFS_LATCH, lat);
		nq = wq.size();
		m = n_erase;
		nvw(8'h16, 1'b0);
		chk("eep_n", wq.size(), nq + 1);
		chk("eep", wq[nq], {2'h0, ptr[21:0], lat});
		chk("eep_erase", n_erase, m);
		// Flash erase whose array reports failure
		nvw(8'h96, 1'b1);
		chk("erase_n", n_erase, m + 1);
		chk("erase_nowr", wq.size(), nq + 1);
		// Both configuration region codes
		for (int r = 0; r < 2; r++) begin
			nq = wq.size();
			nvw(r ? 8'hC6 : 8'h46, 1'b0);
			chk("cfg_space", wq[nq + HB - 1][31:30], SP_CFG);
		end
		report_and_stop();
	end

	// Watchdog well beyond the expected run of some thirteen hundred cycles
	initial begin
		#300000;
		num_errors++;
		report_and_stop();
	end
endmodule

bind tfac_ctrl tfac_checker #(.HOLD_BYTES(HOLD_BYTES)) i_tfac_checker (.*);

// ===== tb/tfac_checker.sv
// Assertion checker on the ports of the table access control block
`timescale 1ns/1ps
module tfac_checker
	import tfac_pkg::*;
#(
	parameter int HOLD_BYTES = 32
) (
	input wire logic              sys_clk_in, rst_in, reg_wr_in, reg_rd_in,
	input wire logic [REG_AW-1:0] reg_addr_in,
	input wire logic [DW-1:0]     reg_wdata_in, reg_rdata_out,
	input wire logic              op_valid_in, op_store_in, op_busy_out,
	input wire logic              mem_rd_out, mem_wr_out, mem_erase_out, mem_prog_out,
	input wire logic [1:0]        mem_space_out,
	input wire logic [PTR_W-1:0]  mem_addr_out,
	input wire logic              done_flag_out, write_active_out
);
	// ==========================================================
	// Clocking and building blocks
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	sequence s_eep_load; mem_wr_out && mem_space_out == SP_EEPROM; endsequence
	sequence s_commit; mem_prog_out; endsequence
	sequence s_rd_pulse; mem_rd_out ##1 !mem_rd_out; endsequence

	// ==========================================================
	// Properties
	property p_unlock_zero; reg_rd_in && reg_addr_in == OFS_UNLOCK |=> reg_rdata_out == 8'h00;
	endproperty
	a_unlock_zero: assert property (p_unlock_zero) else $error("unlock port read nonzero");
	// Read data may only appear in the cycle after a read strobe
	property p_rd_idle; reg_rdata_out != 8'h00 |-> $past(reg_rd_in); endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data without strobe");
	property p_tbl_read; op_valid_in && !op_store_in && !op_busy_out && !write_active_out
		|=> s_rd_pulse; endproperty
	a_tbl_read: assert property (p_tbl_read) else $error("table read gave no array read");
	property p_store; op_valid_in && op_store_in |=> !mem_rd_out; endproperty
	a_store: assert property (p_store) else $error("table store read the array");
	property p_space; mem_rd_out |-> mem_space_out ==
		(mem_addr_out[PTR_CFG_BIT] ? SP_CFG : SP_FLASH); endproperty
	a_space: assert property (p_space) else $error("read space wrong");
	property p_erase; mem_erase_out |-> mem_space_out != SP_EEPROM &&
		mem_addr_out % HOLD_BYTES == 0; endproperty
	a_erase: assert property (p_erase) else $error("erase misplaced");
	property p_eep; s_eep_load |=> s_commit; endproperty
	a_eep: assert property (p_eep) else $error("eeprom load without commit");
	property p_done; $fell(write_active_out) |-> done_flag_out; endproperty
	a_done: assert property (p_done) else $error("completion without done flag");
	property p_done_hold; done_flag_out &&
		!(reg_wr_in && reg_addr_in == OFS_FLAG7 && !reg_wdata_in[FB_DONE]) |=> done_flag_out;
	endproperty
	a_done_hold: assert property (p_done_hold) else $error("done flag dropped");
	// The timer keeps start up well past the commit pulse
	property p_hold; mem_prog_out || mem_erase_out |=> write_active_out [*8]; endproperty
	a_hold: assert property (p_hold) else $error("start cleared early");
	property p_bound; $rose(write_active_out) |-> ##[1:600] !write_active_out; endproperty
	a_bound: assert property (p_bound) else $error("write never completed");
	property p_active; mem_prog_out || mem_erase_out |-> write_active_out && op_busy_out;
	endproperty
	a_active: assert property (p_active) else $error("array change while idle");
endmodule

// ===== tb/tfac_mem_model.sv
// Behavioural model of the nonvolatile arrays behind the control block
`timescale 1ns/1ps
module tfac_mem_model
	import tfac_pkg::*;
(
	input  wire logic             clk_in,    // System clock
	input  wire logic             rd_in,     // Array read
	input  wire logic [PTR_W-1:0] addr_in,   // Byte address
	input  wire logic             fail_in,   // Bench orders a failed write
	output logic      [DW-1:0]    rdata_out, // Read byte
	output logic                  fault_out  // Failure report
);
	logic [DW-1:0] last_r = 8'h00;
	// Data is valid only while the strobe stands; otherwise a stale inverse shows
	assign rdata_out = rd_in ? addr_in[7:0] ^ addr_in[15:8] ^ 8'h5A : ~last_r;
	assign fault_out = fail_in;
	// Remember the last byte so the idle value always differs from it
	always @(posedge clk_in) begin
		if (rd_in)
			last_r <= rdata_out;
	end
endmodule
